// File: hdl/csp_top.v
// Codec serial control port: 2-wire and 3-wire register access
//
// Functional notes
// - Shift address and direction bit, MSB first
// - Acknowledge matching address, else go idle
// - Write is index, high byte, low byte
// - Stop ends transfer; back to idle
// - Out-of-sequence start or stop aborts transfer
// - Chip-select level picks the bus address
// - Auto-increment write: bytes to consecutive registers
// - Repeated start with read bit starts transmit
// - Send register bytes MSB first, master acks
// - Auto-increment read walks increasing indices
// - 3-wire samples data on rising clock
// - 3-wire commit on chip-select rising edge
// - 3-wire read returns data on read pin
// - Write to index zero resets all registers
// - Index zero part code, one revision
// - Global enable bit zero at index 0ch
// - Mode pin selects 2-wire or 3-wire
// - Enable resynchronised into audio clock domain
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.vh"

module csp_top #(
  parameter [15:0] PART_ID  = 16'h5a01,
  parameter [7:0]  REV_NUM  = 8'h01
) (
  input  wire clk_sys,
  input  wire nrst,
  input  wire clk_audio,
  input  wire nrst_audio,
  input  wire mode_sel,
  input  wire cs_n_pin,
  input  wire sclk_pin,
  input  wire serial_data_io_in,
  output wire serial_data_io_out,
  output reg  serial_data_io_oe,
  output reg  serial_read_out,
  output wire global_enable_audio,
  output wire auto_inc
);

  // Arbitrary identity values above; not tied to any real part

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_IDX  = 7'h04;
  localparam [6:0] S_DH   = 7'h08;
  localparam [6:0] S_DL   = 7'h10;
  localparam [6:0] S_RD   = 7'h20;
  localparam [6:0] S_WAIT = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  wire [3:0] pins_s;
  wire       mode_s;
  wire       cs_s;
  wire       scl_s;
  wire       sda_s;
  reg        scl_d;
  reg        sda_d;
  reg        cs_d;
  reg [2:0]  warm;

  csp_sync #(
    .W (4)
  ) u_pin_sync (
    .clk   (clk_sys),
    .rst_n (nrst),
    .d     ({mode_sel, cs_n_pin, sclk_pin, serial_data_io_in}),
    .q     (pins_s)
  );

  assign mode_s = pins_s[3];
  assign cs_s   = pins_s[2];
  assign scl_s  = pins_s[1];
  assign sda_s  = pins_s[0];

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      warm  <= 3'h0;
      scl_d <= 1'b0;
      sda_d <= 1'b1;
      cs_d  <= 1'b1;
    end else begin
      warm  <= {warm[1:0], 1'b1};
      scl_d <= scl_s;
      sda_d <= sda_s;
      cs_d  <= cs_s;
    end
  end

  // Edges ignored until synchronisers fill, else a false edge follows reset
  wire armed    = warm[2];
  wire scl_rise = armed & scl_s & ~scl_d;
  wire scl_fall = armed & ~scl_s & scl_d;
  // Data moving while clock high marks start or stop
  wire start_c  = armed & scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = armed & scl_s & scl_d & ~sda_d & sda_s;
  wire cs_rise  = armed & cs_s & ~cs_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg        gen;
  reg        ainc;
  reg        wr_stb;
  reg [6:0]  wr_idx;
  reg [15:0] wr_dat;

  // Bits passed in so callers re-evaluate when they change
  function [15:0] rd_data;
    input [6:0] i;
    input       g;
    input       a;
    begin
      rd_data = 16'h0000;
      if (i == `CSP_IDX_PART)
        rd_data = PART_ID;
      else if (i == `CSP_IDX_REV)
        rd_data = {8'h00, REV_NUM};
      else if (i == `CSP_IDX_GEN)
        rd_data[`CSP_GEN_BIT] = g;
      else if (i == `CSP_IDX_AINC)
        rd_data[`CSP_AINC_BIT] = a;
    end
  endfunction

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gen  <= `CSP_GEN_RST;
      ainc <= `CSP_AINC_RST;
    end else if (wr_stb) begin
      if (wr_idx == `CSP_IDX_PART) begin
        gen  <= `CSP_GEN_RST;
        ainc <= `CSP_AINC_RST;
      end else if (wr_idx == `CSP_IDX_GEN) begin
        gen <= wr_dat[`CSP_GEN_BIT];
      end else if (wr_idx == `CSP_IDX_AINC) begin
        ainc <= wr_dat[`CSP_AINC_BIT];
      end
    end
  end

  assign auto_inc = ainc;

  // Enable crosses into audio clock domain
  csp_sync #(
    .W (1)
  ) u_audio_sync (
    .clk   (clk_audio),
    .rst_n (nrst_audio),
    .d     (gen),
    .q     (global_enable_audio)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial protocol engines

  reg [6:0]  state;
  reg [3:0]  cnt;
  reg        ack_ph;
  reg        lo_sel;
  reg [7:0]  rx;
  reg [6:0]  idx;
  reg [7:0]  dhi;
  reg [15:0] tx;
  reg [4:0]  sp_cnt;
  reg [23:0] sp_sh;
  reg        sp_rd;
  reg [15:0] sp_tx;

  wire [6:0]  dev_addr = cs_s ? `CSP_ADDR_CS_HI : `CSP_ADDR_CS_LO;
  wire [15:0] rd_word  = rd_data(idx, gen, ainc);
  wire [6:0]  sp_idx   = {sp_sh[5:0], sda_s};
  wire [15:0] sp_word  = rd_data(sp_idx, gen, ainc);

  // Open drain: only ever pulls low
  assign serial_data_io_out = 1'b0;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state             <= S_IDLE;
      cnt               <= 4'h0;
      ack_ph            <= 1'b0;
      lo_sel            <= 1'b0;
      rx                <= 8'h00;
      idx               <= 7'h00;
      dhi               <= 8'h00;
      tx                <= 16'h0000;
      serial_data_io_oe <= 1'b0;
      serial_read_out   <= 1'b0;
      sp_cnt            <= 5'h00;
      sp_sh             <= 24'h000000;
      sp_rd             <= 1'b0;
      sp_tx             <= 16'h0000;
      wr_stb            <= 1'b0;
      wr_idx            <= 7'h00;
      wr_dat            <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (mode_s) begin
        state             <= S_IDLE;
        ack_ph            <= 1'b0;
        serial_data_io_oe <= 1'b0;
        if (cs_s) begin
          sp_cnt          <= 5'h00;
          sp_rd           <= 1'b0;
          serial_read_out <= 1'b0;
          if (cs_rise && sp_cnt == `CSP_FRAME_BITS && !sp_sh[23]) begin
            wr_stb <= 1'b1;
            wr_idx <= sp_sh[22:16];
            wr_dat <= sp_sh[15:0];
          end
        end else if (scl_rise) begin
          sp_sh <= {sp_sh[22:0], sda_s};
          // Overlong frames are never committed
          if (sp_cnt < `CSP_FRAME_BITS)
            sp_cnt <= sp_cnt + 5'h01;
          else
            sp_cnt <= `CSP_FRAME_OVER;
          if (sp_cnt == `CSP_FRAME_HDR && sp_sh[6]) begin
            sp_rd           <= 1'b1;
            serial_read_out <= sp_word[15];
            sp_tx           <= {sp_word[14:0], 1'b0};
          end else if (sp_rd) begin
            serial_read_out <= sp_tx[15];
            sp_tx           <= {sp_tx[14:0], 1'b0};
          end
        end
      end else begin
        sp_cnt          <= 5'h00;
        sp_rd           <= 1'b0;
        serial_read_out <= 1'b0;
        if (start_c) begin
          ack_ph            <= 1'b0;
          cnt               <= 4'h0;
          serial_data_io_oe <= 1'b0;
          // Clock rise ahead of a repeated start shifts one bit
          // Repeated start after index
          if (state == S_IDLE || state == S_WAIT ||
              (state == S_DH && cnt <= 4'h1 && !ack_ph))
            state <= S_ADDR;
          else
            state <= S_IDLE;
        end else if (stop_c) begin
          state             <= S_IDLE;
          ack_ph            <= 1'b0;
          serial_data_io_oe <= 1'b0;
        end else begin
          case (state)
            S_IDLE: begin
              serial_data_io_oe <= 1'b0;
            end
            S_ADDR, S_IDX, S_DH, S_DL: begin
              if (scl_rise && !ack_ph && cnt < `CSP_BYTE_BITS) begin
                rx  <= {rx[6:0], sda_s};
                cnt <= cnt + 4'h1;
              end
              if (scl_fall && !ack_ph && cnt == `CSP_BYTE_BITS) begin
                if (state == S_ADDR && rx[7:1] != dev_addr) begin
                  state <= S_IDLE;
                end else begin
                  ack_ph            <= 1'b1;
                  serial_data_io_oe <= 1'b1;
                end
                if (state == S_IDX)
                  idx <= rx[6:0];
                if (state == S_DH) begin
                  if (ainc) begin
                    wr_stb <= 1'b1;
                    wr_idx <= idx;
                    wr_dat <= {8'h00, rx};
                    idx    <= idx + 7'h01;
                  end else begin
                    dhi <= rx;
                  end
                end
                if (state == S_DL) begin
                  wr_stb <= 1'b1;
                  wr_idx <= idx;
                  wr_dat <= {dhi, rx};
                end
              end else if (scl_fall && ack_ph) begin
                ack_ph            <= 1'b0;
                cnt               <= 4'h0;
                serial_data_io_oe <= 1'b0;
                if (state == S_ADDR) begin
                  if (rx[0]) begin
                    state             <= S_RD;
                    lo_sel            <= 1'b0;
                    tx                <= rd_word;
                    serial_data_io_oe <= ~rd_word[15];
                  end else begin
                    state <= S_IDX;
                  end
                end else if (state == S_IDX) begin
                  state <= S_DH;
                end else if (state == S_DH) begin
                  state <= ainc ? S_DH : S_DL;
                end else begin
                  state <= S_IDLE;
                end
              end
            end
            S_RD: begin
              if (!ack_ph) begin
                if (scl_rise && cnt < `CSP_BYTE_BITS)
                  cnt <= cnt + 4'h1;
                // Drive bits MSB first on falls
                if (scl_fall) begin
                  tx <= {tx[14:0], 1'b0};
                  if (cnt == `CSP_BYTE_BITS) begin
                    ack_ph            <= 1'b1;
                    serial_data_io_oe <= 1'b0;
                  end else begin
                    serial_data_io_oe <= ~tx[14];
                  end
                end
              end else begin
                if (scl_rise && cnt == `CSP_BYTE_BITS) begin
                  if (sda_s) begin
                    state <= S_WAIT;
                  end else begin
                    cnt <= 4'h0;
                    if (lo_sel && ainc)
                      idx <= idx + 7'h01;
                  end
                end
                if (scl_fall && cnt == 4'h0) begin
                  ack_ph <= 1'b0;
                  if (lo_sel) begin
                    lo_sel            <= 1'b0;
                    tx                <= rd_word;
                    serial_data_io_oe <= ~rd_word[15];
                  end else begin
                    lo_sel            <= 1'b1;
                    serial_data_io_oe <= ~tx[15];
                  end
                end
              end
            end
            S_WAIT: begin
              serial_data_io_oe <= 1'b0;
            end
            default: begin
              state             <= S_IDLE;
              serial_data_io_oe <= 1'b0;
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/csp_defs.vh
// Constants for the codec serial control port
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

// 2-wire bus addresses, chosen by the chip-select pin level
`define CSP_ADDR_CS_LO   7'h34
`define CSP_ADDR_CS_HI   7'h36

// Register indices
`define CSP_IDX_PART     7'h00
`define CSP_IDX_REV      7'h01
`define CSP_IDX_GEN      7'h0c
`define CSP_IDX_AINC     7'h0d

// Field positions
`define CSP_GEN_BIT      0
`define CSP_AINC_BIT     0

// Reset values
`define CSP_GEN_RST      1'b0
`define CSP_AINC_RST     1'b0

// Serial timing counts
`define CSP_BYTE_BITS    4'h8
`define CSP_FRAME_BITS   5'h18
`define CSP_FRAME_HDR    5'h07
`define CSP_FRAME_OVER   5'h19

`endif

// File: hdl/csp_sync.v
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module csp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// File: bench/csp_chk_chk.sv
// Checker for the serial control port pins
`timescale 1ns/1ps
`default_nettype none
module csp_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mode_sel,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic serial_data_io_out,
  input wire logic serial_data_io_oe,
  input wire logic serial_read_out,
  input wire logic auto_inc
);
  logic [7:0] run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Longest pull is an ack plus eight zero bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) run <= 8'h00;
    else run <= serial_data_io_oe ? run + 8'h01 : 8'h00;
  end
  out_low_a: assert property (serial_data_io_out == 1'b0)
    else $error("data out not low");
  oe_quiet_a: assert property (mode_sel [*6] |-> !serial_data_io_oe)
    else $error("pull in 3-wire mode");
  rd_quiet_a: assert property ((!mode_sel) [*6] |-> !serial_read_out)
    else $error("read pin busy in 2-wire mode");
  rd_idle_a: assert property (cs_n_pin [*6] |-> !serial_read_out)
    else $error("read pin busy while deselected");
  oe_low_phase_a: assert property ($changed(serial_data_io_oe) |-> !sclk_pin)
    else $error("data line moved with clock high");
  rd_edge_a: assert property ($changed(serial_read_out) |-> sclk_pin || cs_n_pin)
    else $error("read bit moved with clock low");
  ainc_commit_a: assert property ($changed(auto_inc) && mode_sel |-> cs_n_pin)
    else $error("3-wire commit before select rise");
  oe_bound_a: assert property (run < 8'h78)
    else $error("data line held too long");
  cover property ($rose(serial_data_io_oe));
  cover property ($rose(serial_read_out));
  cover property ($rose(auto_inc));
endmodule
bind csp_top csp_chk chk (.clk_sys, .nrst, .mode_sel, .cs_n_pin, .sclk_pin,
  .serial_data_io_out, .serial_data_io_oe, .serial_read_out, .auto_inc);
`default_nettype wire

// File: bench/csp_host.sv
// Host controller model for both serial modes
`timescale 1ns/1ps
`default_nettype none
module csp_host (
  output logic     sclk_pin,
  output logic     cs_n_pin,
  output logic     drv,
  input  wire logic seen
);
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b0;
    drv = 1'b1;
  end
  // Data moves only while the clock is low
  task automatic bit1(input logic b, output logic s);
    drv = b;
    #31.25 sclk_pin = 1'b1;
    #50 s = seen;
    #12.5 sclk_pin = 1'b0;
    #31.25;
  endtask
  task automatic tw_start;
    drv = 1'b1;
    #31.25 sclk_pin = 1'b1;
    #31.25 drv = 1'b0;
    #31.25 sclk_pin = 1'b0;
    #31.25;
  endtask
  task automatic tw_stop;
    drv = 1'b0;
    #31.25 sclk_pin = 1'b1;
    #31.25 drv = 1'b1;
    #62.5;
  endtask
  task automatic tw_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(b[i], s);
    bit1(1'b1, s);
    ack = !s;
  endtask
  task automatic tw_read(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
    bit1(last, s);
  endtask
  task automatic tr_frame(input logic [23:0] f, input int n, output logic [15:0] r);
    logic s;
    r = 16'h0000;
    sclk_pin = 1'b0;
    #62.5 cs_n_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      bit1(f[23 - i], s);
      if (i > 6 && i < 23) r = {r[14:0], s};
    end
    #62.5 cs_n_pin = 1'b1;
    drv = !drv;
    #250;
  endtask
endmodule
`default_nettype wire

// File: bench/codec_serial_control_port_test.sv
// Self-checking bench for the serial control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t %s", $time, m); end end
module codec_serial_control_port_test;
  // Arbitrary identity values
  localparam logic [15:0] PID = 16'h3c5a;
  localparam logic [7:0]  REV = 8'h07;
  logic       clk_sys = 1'b0;
  logic       clk_audio = 1'b0;
  logic       nrst = 1'b0;
  logic       mode_sel = 1'b0;
  logic [6:0] addr = 7'h34;
  int         n_errors = 0;
  int         checked = 0;
  wire logic  sclk_pin, cs_n_pin, drv, oe, rdo, gen, ainc;
  wire logic  sda = mode_sel ? drv : (drv & !oe);
  always #5 clk_sys = !clk_sys;
  always #21 clk_audio = !clk_audio;
  csp_top #(.PART_ID(PID), .REV_NUM(REV)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_audio(clk_audio), .nrst_audio(nrst),
    .mode_sel(mode_sel), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .serial_data_io_in(sda), .serial_data_io_out(), .serial_data_io_oe(oe),
    .serial_read_out(rdo), .global_enable_audio(gen), .auto_inc(ainc));
  csp_host host (.sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .drv(drv),
    .seen(mode_sel ? rdo : sda));
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic send(input logic [31:0] b, input int nb, output logic [3:0] k);
    k = 4'h0;
    host.tw_start;
    for (int i = 0; i < nb; i++) host.tw_byte(b[31 - 8 * i -: 8], k[3 - i]);
  endtask
  task automatic reg_wr(input logic [6:0] idx, input logic [15:0] d);
    logic [3:0] k;
    send({addr, 1'b0, 1'b0, idx, d}, 4, k);
    host.tw_stop;
    `CHK(k, 4'hf, "write ack")
  endtask
  task automatic reg_rd(input logic [6:0] idx, input int nb, output logic [31:0] v);
    logic [3:0] k;
    logic [3:0] r;
    send({addr, 1'b0, 1'b0, idx, 16'h0000}, 2, k);
    send({addr, 1'b1, 24'h000000}, 1, r);
    for (int i = 0; i < nb; i++) host.tw_read(i == nb - 1, v[31 - 8 * i -: 8]);
    host.tw_stop;
    `CHK({k, r}, 8'hc8, "read ack")
  endtask
  // Bounded wait, since the audio side lags
  task automatic wait_en(input logic v);
    int i;
    for (i = 0; i < 200 && gen !== v; i++) @(posedge clk_sys);
    `CHK(gen, v, "global enable")
    if (i == 200) give_verdict;
  endtask
  task automatic sc_ids;
    logic [31:0] v;
    `CHK({oe, rdo, gen, ainc}, 4'h0, "reset values")
    reg_rd(7'h00, 2, v);
    `CHK(v[31:16], PID, "part id")
    reg_rd(7'h01, 4, v);
    `CHK(v, {2{8'h00, REV}}, "revision")
    reg_wr(7'h0c, 16'h0001);
    wait_en(1'b1);
    reg_rd(7'h0c, 2, v);
    `CHK(v[31:16], 16'h0001, "enable readback")
  endtask
  task automatic sc_addr;
    logic [3:0] k;
    host.cs_n_pin = 1'b1;
    send({8'h68, 24'h0}, 1, k);
    host.tw_stop;
    `CHK(k, 4'h0, "wrong address")
    addr = 7'h36;
    reg_wr(7'h0c, 16'h0000);
    wait_en(1'b0);
    host.cs_n_pin = 1'b0;
    addr = 7'h34;
    send({addr, 1'b0, 8'h0c, 8'h00, 8'h00}, 3, k);
    send({8'h01, 24'h0}, 1, k);
    host.tw_stop;
    `CHK(k, 4'h0, "byte after restart")
    wait_en(1'b0);
  endtask
  task automatic sc_ainc;
    logic [31:0] v;
    logic [3:0] k;
    reg_wr(7'h0d, 16'h0001);
    `CHK(ainc, 1'b1, "auto increment")
    reg_rd(7'h00, 4, v);
    `CHK(v, {PID, 8'h00, REV}, "increasing read")
    send({addr, 1'b0, 8'h0c, 8'h01, 8'h00}, 4, k);
    host.tw_stop;
    wait_en(1'b1);
    `CHK({k, ainc}, 5'h1e, "byte writes")
    reg_wr(7'h0d, 16'h0001);
    send({addr, 1'b0, 8'h00, 8'h00, 8'h00}, 3, k);
    host.tw_stop;
    wait_en(1'b0);
    `CHK({k, ainc}, 5'h1c, "soft reset")
  endtask
  task automatic sc_three;
    logic [15:0] r;
    host.cs_n_pin = 1'b1;
    @(posedge clk_sys);
    #1 mode_sel = 1'b1;
    repeat (8) @(posedge clk_sys);
    host.tr_frame({1'b0, 7'h0c, 16'h0001}, 24, r);
    wait_en(1'b1);
    host.tr_frame({1'b1, 7'h00, 16'h0000}, 24, r);
    `CHK(r, PID, "serial read")
    host.tr_frame({1'b0, 7'h0d, 16'h0001}, 23, r);
    `CHK(ainc, 1'b0, "short frame")
    host.tr_frame({1'b0, 7'h0d, 16'h0001}, 24, r);
    `CHK(ainc, 1'b1, "frame commit")
  endtask
  initial begin
    #500us;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (6) @(posedge clk_sys);
    sc_ids;
    sc_addr;
    sc_ainc;
    sc_three;
    give_verdict;
  end
endmodule
`default_nettype wire
